// >>> hw/ue_baud_gen.sv
// prescaler and eight-bit auto-reload baud timer
`include "ue_defines.svh"
`default_nettype none
module ue_baud_gen import ue_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire ue_baud_cfg_s cfg_in,
    input wire logic restart_in,
    output logic ovf_out
);
    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    logic [5:0] pre_cnt_reg;
    logic [7:0] timer_reg;
    wire [5:0] pre_div = (cfg_in.prescale_select == `UE_PSC_DIV12) ? `UE_DIV_12 :
        (cfg_in.prescale_select == `UE_PSC_DIV4) ? `UE_DIV_4 :
        (cfg_in.prescale_select == `UE_PSC_DIV48) ? `UE_DIV_48 : `UE_DIV_OTHER;
    wire pre_wrap = (pre_cnt_reg == pre_div - 6'd1);
    wire timer_tick = cfg_in.timer_clock_select | pre_wrap;
    wire timer_wrap = timer_tick && (timer_reg == `UE_TIMER_MAX);

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pre_cnt_reg <= 6'h00;
        end else if (restart_in || pre_wrap) begin
            pre_cnt_reg <= 6'h00;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 6'd1;
        end
    end

    // ----------------------------------------
    // auto-reload timer
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            timer_reg <= 8'h00;
            ovf_out <= 1'b0;
        end else if (restart_in) begin
            timer_reg <= cfg_in.reload;
            ovf_out <= 1'b0;
        end else begin
            ovf_out <= timer_wrap;
            if (timer_wrap) begin
                timer_reg <= cfg_in.reload;
            end else if (timer_tick) begin
                timer_reg <= timer_reg + 8'd1;
            end
        end
    end

    a_timer_reload: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        (timer_wrap && !restart_in) |=> (ovf_out && timer_reg == $past(cfg_in.reload)))
        else $error("timer overflow did not reload");
endmodule : ue_baud_gen
`default_nettype wire

// >>> hw/ue_sync.sv
// two flip-flop synchroniser for a pin input
`default_nettype none
module ue_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : ue_sync
`default_nettype wire

// >>> hw/ue_uart8.sv
// eight- and nine-bit mode serial port: transmitter, receiver, control flags
`include "ue_defines.svh"
`default_nettype none
module ue_uart8 import ue_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic ctrl_wr_in,
    input wire ue_ctrl_s ctrl_wdata_in,
    output ue_ctrl_s ctrl_out,
    input wire logic buf_wr_in,
    input wire logic [7:0] buf_wdata_in,
    output logic [7:0] buf_rdata_out,
    input wire ue_baud_cfg_s baud_cfg_in,
    input wire logic irq_enable_in,
    output logic serial_irq_out,
    output logic tx_busy_out,
    input wire logic serial_in_pin_in,
    output logic serial_out_pin_out
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    ue_ctrl_s ctrl_reg;
    ue_ctrl_s ctrl_next;
    ue_tx_state_e tx_state_reg;
    ue_rx_state_e rx_state_reg;
    logic [8:0] tx_shift_reg;
    logic [3:0] tx_cnt_reg;
    logic tx_nine_reg;
    logic tx_half_reg;
    logic tx_ovf;
    logic rx_ovf;
    logic rx_start_edge;
    logic rx_s;
    logic rx_prev_reg;
    logic rx_half_reg;
    logic rx_nine_reg;
    logic [3:0] rx_cnt_reg;
    logic [8:0] rx_shift_reg;
    logic [7:0] rx_buf_reg;

    // ----------------------------------------
    // baud timing
    // ----------------------------------------
    ue_baud_gen u_tx_baud (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .cfg_in(baud_cfg_in),
        .restart_in(1'b0),
        .ovf_out(tx_ovf)
    );

    ue_baud_gen u_rx_baud (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .cfg_in(baud_cfg_in),
        .restart_in(rx_start_edge),
        .ovf_out(rx_ovf)
    );

    ue_sync #(.RST_VAL(`UE_LINE_IDLE)) u_rx_sync (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .async_in(serial_in_pin_in),
        .sync_out(rx_s)
    );

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire tx_tick = tx_ovf & tx_half_reg;
    wire rx_sample = rx_ovf & rx_half_reg;
    wire [3:0] tx_nbits = tx_nine_reg ? `UE_DATA_BITS_9 : `UE_DATA_BITS_8;
    wire [3:0] rx_nbits = rx_nine_reg ? `UE_DATA_BITS_9 : `UE_DATA_BITS_8;
    wire tx_idle = (tx_state_reg == UE_TX_IDLE);
    wire tx_launch = buf_wr_in && tx_idle;
    wire tx_to_stop = (tx_state_reg == UE_TX_DATA) && tx_tick && (tx_cnt_reg == tx_nbits);
    wire rx_idle = (rx_state_reg == UE_RX_IDLE);
    assign rx_start_edge = rx_idle && ctrl_reg.rx_enable_bit && rx_prev_reg && !rx_s;
    wire rx_frame_end = (rx_state_reg == UE_RX_STOP) && rx_sample;
    wire [7:0] rx_byte = rx_nine_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
    wire rx_tag_bit = rx_nine_reg ? rx_shift_reg[8] : rx_s;
    wire rx_accept = !ctrl_reg.rx_done_flag
        && (!ctrl_reg.multiproc_check_enable || rx_tag_bit);
    wire rx_load = rx_frame_end && rx_accept;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr_in) begin
            ctrl_next = ctrl_wdata_in;
        end
        ctrl_next.reserved6 = 1'b0;
        if (tx_to_stop) begin
            ctrl_next.tx_done_flag = 1'b1;
        end
        if (rx_load) begin
            ctrl_next.rx_done_flag = 1'b1;
            ctrl_next.received_stop_bit = rx_tag_bit;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_reg <= `UE_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign ctrl_out = ctrl_reg;
    assign serial_irq_out = irq_enable_in && (ctrl_reg.tx_done_flag || ctrl_reg.rx_done_flag);
    assign tx_busy_out = !tx_idle;
    assign buf_rdata_out = rx_buf_reg;

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_half_reg <= 1'b0;
        end else if (tx_ovf) begin
            tx_half_reg <= !tx_half_reg;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_state_reg <= UE_TX_IDLE;
            tx_shift_reg <= 9'h000;
            tx_cnt_reg <= 4'h0;
            tx_nine_reg <= 1'b0;
            serial_out_pin_out <= `UE_LINE_IDLE;
        end else begin
            unique case (tx_state_reg)
                UE_TX_IDLE: begin
                    serial_out_pin_out <= `UE_LINE_IDLE;
                    if (tx_launch) begin
                        tx_shift_reg <= {ctrl_reg.tx_ninth_bit, buf_wdata_in};
                        tx_nine_reg <= ctrl_reg.frame_width_select;
                        tx_cnt_reg <= 4'h0;
                        tx_state_reg <= UE_TX_ARM;
                    end
                end
                UE_TX_ARM: begin
                    if (tx_tick) begin
                        serial_out_pin_out <= 1'b0;
                        tx_state_reg <= UE_TX_DATA;
                    end
                end
                UE_TX_DATA: begin
                    if (tx_to_stop) begin
                        serial_out_pin_out <= 1'b1;
                        tx_state_reg <= UE_TX_STOP;
                    end else if (tx_tick) begin
                        serial_out_pin_out <= tx_shift_reg[0];
                        tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                        tx_cnt_reg <= tx_cnt_reg + 4'd1;
                    end
                end
                UE_TX_STOP: begin
                    if (tx_tick) begin
                        tx_state_reg <= UE_TX_IDLE;
                    end
                end
                default: begin
                    tx_state_reg <= UE_TX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_prev_reg <= `UE_LINE_IDLE;
            rx_half_reg <= 1'b0;
        end else begin
            rx_prev_reg <= rx_s;
            if (rx_start_edge || ((rx_state_reg == UE_RX_START) && rx_ovf)) begin
                rx_half_reg <= 1'b0;
            end else if (rx_ovf) begin
                rx_half_reg <= !rx_half_reg;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_state_reg <= UE_RX_IDLE;
            rx_cnt_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
            rx_nine_reg <= 1'b0;
        end else begin
            unique case (rx_state_reg)
                UE_RX_IDLE: begin
                    if (rx_start_edge) begin
                        rx_nine_reg <= ctrl_reg.frame_width_select;
                        rx_cnt_reg <= 4'h0;
                        rx_state_reg <= UE_RX_START;
                    end
                end
                UE_RX_START: begin
                    if (rx_ovf) begin
                        rx_state_reg <= rx_s ? UE_RX_IDLE : UE_RX_DATA;
                    end
                end
                UE_RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_reg <= {rx_s, rx_shift_reg[8:1]};
                        rx_cnt_reg <= rx_cnt_reg + 4'd1;
                        if (rx_cnt_reg == rx_nbits - 4'd1) begin
                            rx_state_reg <= UE_RX_STOP;
                        end
                    end
                end
                UE_RX_STOP: begin
                    if (rx_sample) begin
                        rx_state_reg <= UE_RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= UE_RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_buf_reg <= 8'h00;
        end else if (rx_load) begin
            rx_buf_reg <= rx_byte;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_tx_arm_tick;
        (tx_state_reg == UE_TX_ARM) && tx_tick;
    endsequence

    sequence s_stop_entry;
        tx_to_stop;
    endsequence

    a_tx_start_low: assert property (s_tx_arm_tick |=> !serial_out_pin_out)
        else $error("start bit not driven low");

    a_tx_done_timing: assert property (s_stop_entry |=> ($past(tx_cnt_reg) == tx_nbits)
        && ctrl_reg.tx_done_flag && serial_out_pin_out)
        else $error("transmit done flag not set at stop bit");

    a_tx_idle_high: assert property (tx_idle && $past(tx_idle) |-> serial_out_pin_out)
        else $error("idle line not high");

    a_tx_line_paced: assert property ($changed(serial_out_pin_out) |-> $past(tx_tick))
        else $error("line changed off a bit boundary");

    a_rx_enable_gate: assert property ((rx_idle && !ctrl_reg.rx_enable_bit) |=> rx_idle)
        else $error("receiver started while disabled");

    a_rx_check_reject: assert property ((rx_frame_end && ctrl_reg.multiproc_check_enable
        && !rx_tag_bit) |-> !rx_load)
        else $error("frame loaded despite a low stop bit");

    a_rx_load_store: assert property (rx_load |=> ctrl_reg.rx_done_flag
        && rx_buf_reg == $past(rx_byte) && ctrl_reg.received_stop_bit == $past(rx_tag_bit))
        else $error("loaded frame not stored");

    a_rx_overrun_keep: assert property ((rx_frame_end && ctrl_reg.rx_done_flag) |=>
        $stable(rx_buf_reg))
        else $error("overrun frame replaced the buffer");

    a_rx_reject_keep: assert property ((rx_frame_end && !rx_accept && !ctrl_wr_in) |=>
        $stable(rx_buf_reg) && $stable(ctrl_reg.received_stop_bit))
        else $error("rejected frame changed the buffer");

    a_irq_on_flag: assert property (($rose(ctrl_reg.tx_done_flag)
        || $rose(ctrl_reg.rx_done_flag)) && irq_enable_in |-> serial_irq_out)
        else $error("serial interrupt missing");

endmodule : ue_uart8
`default_nettype wire

// >>> include/ue_defines.svh
// constants for the eight-bit serial port
`ifndef UE_DEFINES_SVH
`define UE_DEFINES_SVH

// ----------------------------------------
// control register layout
// ----------------------------------------
`define UE_CTRL_RESET 8'h00
`define UE_CTRL_FWS_BIT 7
`define UE_CTRL_MCE_BIT 5
`define UE_CTRL_REN_BIT 4
`define UE_CTRL_TX9_BIT 3
`define UE_CTRL_RSB_BIT 2
`define UE_CTRL_TDF_BIT 1
`define UE_CTRL_RDF_BIT 0

// ----------------------------------------
// frame and timer constants
// ----------------------------------------
`define UE_DATA_BITS_8 4'd8
`define UE_DATA_BITS_9 4'd9
`define UE_LINE_IDLE 1'b1
`define UE_TIMER_MAX 8'hff
`define UE_PSC_DIV12 2'b00
`define UE_PSC_DIV4 2'b01
`define UE_PSC_DIV48 2'b10
`define UE_DIV_12 6'd12
`define UE_DIV_4 6'd4
`define UE_DIV_48 6'd48
`define UE_DIV_OTHER 6'd8

`endif

// >>> include/ue_pkg.sv
// types shared by the eight-bit serial port
`default_nettype none
package ue_pkg;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic frame_width_select;
        logic reserved6;
        logic multiproc_check_enable;
        logic rx_enable_bit;
        logic tx_ninth_bit;
        logic received_stop_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } ue_ctrl_s;

    // baud timer setup
    typedef struct packed {
        logic timer_clock_select;
        logic [1:0] prescale_select;
        logic [7:0] reload;
    } ue_baud_cfg_s;

    typedef enum logic [3:0] {
        UE_TX_IDLE = 4'b0001,
        UE_TX_ARM = 4'b0010,
        UE_TX_DATA = 4'b0100,
        UE_TX_STOP = 4'b1000
    } ue_tx_state_e;

    typedef enum logic [3:0] {
        UE_RX_IDLE = 4'b0001,
        UE_RX_START = 4'b0010,
        UE_RX_DATA = 4'b0100,
        UE_RX_STOP = 4'b1000
    } ue_rx_state_e;

endpackage : ue_pkg
`default_nettype wire

// >>> sim/ue_line_model.sv
// partner model: remote serial transmitter and receiver on the line
`default_nettype none
module ue_line_model (
    input wire logic clk_sys_in,
    input wire logic tx_line_in,
    input wire logic tx_done_in,
    output logic rx_line_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int bit_clks = 8;
    int start_len;
    logic [8:0] cap_bits;
    logic done_b7;
    logic done_stop;
    initial rx_line_out = 1'h1;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick();
        @(posedge clk_sys_in);
        #1;
    endtask : tick
    // ----------------------------------------
    // sender: start low, data lowest first, stop
    // ----------------------------------------
    task automatic send_frame(input logic [7:0] data, input logic stop);
        logic [9:0] frame;
        frame = {stop, data, 1'h0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys_in);
            rx_line_out <= frame[i];
            repeat (bit_clks - 1) @(posedge clk_sys_in);
        end
        @(posedge clk_sys_in);
        rx_line_out <= 1'h1;
    endtask : send_frame
    // ----------------------------------------
    // receiver: mid-bit samples, start bit length
    // ----------------------------------------
    task automatic capture();
        int n;
        n = 0;
        while (tx_line_in !== 1'h0 && n < 2000) begin
            tick();
            n++;
        end
        start_len = 0;
        while (tx_line_in === 1'h0 && start_len < 200) begin
            tick();
            start_len++;
        end
        repeat (bit_clks + bit_clks / 2 - start_len) tick();
        for (int i = 0; i < 9; i++) begin
            cap_bits[i] = tx_line_in;
            if (i == 7) done_b7 = tx_done_in;
            if (i == 8) done_stop = tx_done_in;
            if (i < 8) repeat (bit_clks) tick();
        end
    endtask : capture
endmodule : ue_line_model
`default_nettype wire

// >>> sim/ue_uart8_tb.sv
// self-checking bench for the eight-bit serial port
`default_nettype none
module ue_uart8_tb import ue_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic ctrl_wr = 1'h0;
    ue_ctrl_s ctrl_wdata = 8'h00;
    ue_ctrl_s ctrl_q;
    logic buf_wr = 1'h0;
    logic [7:0] buf_wdata = 8'h00;
    logic [7:0] buf_q;
    ue_baud_cfg_s baud_cfg = {1'h1, 2'h0, 8'hfc};
    logic irq_en = 1'h0;
    logic irq;
    logic busy;
    logic line_rx;
    logic line_tx;
    int errors = 0;
    int checked = 0;
    always #2.5 clk_sys_in = ~clk_sys_in;
    ue_uart8 ue_uart8_inst (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ctrl_wr_in(ctrl_wr),
        .ctrl_wdata_in(ctrl_wdata), .ctrl_out(ctrl_q), .buf_wr_in(buf_wr),
        .buf_wdata_in(buf_wdata), .buf_rdata_out(buf_q), .baud_cfg_in(baud_cfg),
        .irq_enable_in(irq_en), .serial_irq_out(irq), .tx_busy_out(busy),
        .serial_in_pin_in(line_rx), .serial_out_pin_out(line_tx)
    );
    ue_line_model ue_line_model_inst (
        .clk_sys_in(clk_sys_in), .tx_line_in(line_tx),
        .tx_done_in(ctrl_q.tx_done_flag), .rx_line_out(line_rx)
    );
    // ----------------------------------------
    // common tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick();
        @(posedge clk_sys_in);
        #1;
    endtask : tick
    function automatic ue_ctrl_s mk(input logic fws, input logic mce, input logic ren);
        return {fws, 1'h0, mce, ren, 4'h0};
    endfunction : mk
    task automatic wr_ctrl(input ue_ctrl_s v);
        @(posedge clk_sys_in);
        ctrl_wr <= 1'h1;
        ctrl_wdata <= v;
        @(posedge clk_sys_in);
        ctrl_wr <= 1'h0;
        tick();
    endtask : wr_ctrl
    task automatic wr_buf(input logic [7:0] d);
        @(posedge clk_sys_in);
        buf_wr <= 1'h1;
        buf_wdata <= d;
        @(posedge clk_sys_in);
        buf_wr <= 1'h0;
    endtask : wr_buf
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 3000) begin
            tick();
            n++;
        end
        check(busy, 0);
    endtask : wait_idle
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(ctrl_q, 0);
        check(buf_q, 0);
        check(line_tx, 1);
        check({busy, irq}, 0);
    endtask : t_reset
    task automatic t_tx();
        int lows;
        lows = 0;
        @(posedge clk_sys_in);
        irq_en <= 1'h1;
        wr_ctrl(mk(0, 0, 0));
        fork
            ue_line_model_inst.capture();
            begin
                wr_buf(8'ha5);
                tick();
                check(busy, 1);
                wr_buf(8'h3c);
            end
        join
        check(ue_line_model_inst.cap_bits, {1'h1, 8'ha5});
        check(ue_line_model_inst.done_b7, 0);
        check(ue_line_model_inst.done_stop, 1);
        check(irq, 1);
        wait_idle();
        repeat (24) begin
            tick();
            if (line_tx !== 1'h1) lows++;
        end
        check(lows, 0);
        @(posedge clk_sys_in);
        irq_en <= 1'h0;
        tick();
        check(irq, 0);
    endtask : t_tx
    task automatic t_prescale();
        ue_baud_cfg_s cfg_tab[6] = '{{1'h1, 2'h0, 8'hfc}, {1'h0, 2'h0, 8'hff},
            {1'h0, 2'h1, 8'hff}, {1'h0, 2'h2, 8'hff}, {1'h1, 2'h2, 8'hfc},
            {1'h0, 2'h3, 8'hff}};
        int bits_tab[6] = '{8, 24, 8, 96, 8, 16};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys_in);
            baud_cfg <= cfg_tab[i];
            ue_line_model_inst.bit_clks = bits_tab[i];
            fork
                ue_line_model_inst.capture();
                wr_buf(8'h55);
            join
            check(ue_line_model_inst.start_len, bits_tab[i]);
            check(ue_line_model_inst.cap_bits, {1'h1, 8'h55});
            wait_idle();
        end
    endtask : t_prescale
    task automatic t_nine_bit();
        wr_ctrl(mk(1, 0, 0));
        fork
            ue_line_model_inst.capture();
            wr_buf(8'hc3);
        join
        check(ue_line_model_inst.cap_bits, {1'h0, 8'hc3});
        wait_idle();
        wr_ctrl(ue_ctrl_s'(8'h88));
        fork
            ue_line_model_inst.capture();
            wr_buf(8'h3d);
        join
        check(ue_line_model_inst.cap_bits, {1'h1, 8'h3d});
        wait_idle();
    endtask : t_nine_bit
    task automatic rx_case(input logic [7:0] d, input logic stop, input logic [7:0] eb,
            input logic ed, input logic es);
        ue_line_model_inst.send_frame(d, stop);
        repeat (8) tick();
        check(buf_q, eb);
        check(ctrl_q.rx_done_flag, ed);
        check(ctrl_q.received_stop_bit, es);
    endtask : rx_case
    task automatic t_rx();
        wr_ctrl(mk(0, 0, 0));
        rx_case(8'h96, 1'h1, 8'h00, 1'h0, 1'h0);
        wr_ctrl(mk(0, 0, 1));
        rx_case(8'h96, 1'h1, 8'h96, 1'h1, 1'h1);
        @(posedge clk_sys_in);
        irq_en <= 1'h1;
        tick();
        check(irq, 1);
        rx_case(8'h21, 1'h1, 8'h96, 1'h1, 1'h1);
        wr_ctrl(mk(0, 1, 1));
        rx_case(8'h44, 1'h0, 8'h96, 1'h0, 1'h0);
        rx_case(8'h44, 1'h1, 8'h44, 1'h1, 1'h1);
        wr_ctrl(mk(0, 0, 1));
        rx_case(8'h18, 1'h0, 8'h18, 1'h1, 1'h0);
    endtask : t_rx
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys_in);
        rst_b_in <= 1'h1;
        tick();
        t_reset();
        t_tx();
        t_prescale();
        t_nine_bit();
        @(posedge clk_sys_in);
        baud_cfg <= {1'h1, 2'h0, 8'hfc};
        ue_line_model_inst.bit_clks = 8;
        t_rx();
        stop_test();
    end
    initial begin
        repeat (50000) @(posedge clk_sys_in);
        errors++;
        $display("watchdog expired at %0t", $time);
        stop_test();
    end
endmodule : ue_uart8_tb
`default_nettype wire
